// ---- src/vic_gpr_mem.sv ----
`timescale 1ns/100ps
`default_nettype none
module vic_gpr_mem import vic_pkg::*; #(
  parameter int DEPTH = VIC_GPR_NUM,
  parameter int WIDTH = VIC_ADDR_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (clr) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= VIC_GPR_RESET;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data registered; a write is seen on the read port one cycle later
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else if (clr) begin
      rd_data <= VIC_GPR_RESET;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_gpr_clear;
    clr ##1 !clr [*2] |-> rd_data == VIC_GPR_RESET;
  endproperty
  a_gpr_clear: assert property (p_gpr_clear) else $error("gpr not zero after clear");

endmodule
`default_nettype wire

// ---- src/vic_interrupt_arbiter.sv ----
// What this block does
// - initial reset clears all eight general registers to zero
// - initial reset clears status word: level zero, maskable interrupts off
// - stack pointer reads zero; program counter loads from vector table entry zero
// - initial reset returns status, stack, general, key and base registers to their default values
// - give core a request with winning level and vector number
// - twenty-two maskable systems from twenty-three groups; two share one
// - eight priority levels order maskable requests
// - each system has its own programmable level deciding service order
// - causes are enabled in peripherals; one combined request per system here
// - vector zero for external reset low or watchdog reset; top priority
// - vector n at base plus four n; vector three never raised
// - watchdog overflow in non-maskable mode raises vector two
// - port group zero: eight inputs, vector four, highest maskable system
// - stopwatch vector six combines hundredth, tenth and second ticks
// - clock timer vector seven combines four periodic ticks
// - pwm channel two requests vector eight for its six causes
// - supply voltage detector requests vector nine on low supply
// - pwm channel zero requests vector eleven, six causes combined
// - four plain timers underflow on vectors twelve to fifteen in order
// - vector fifteen is timer three underflow or any pwm three cause
// - equal levels: lower vector number is served first
// - table base resets to 0x8000, low eight bits always zero
// - base writes ignored unless protect key holds 0x96
`timescale 1ns/100ps
`default_nettype none
module vic_interrupt_arbiter import vic_pkg::*; #(
  parameter int SYS_NUM = VIC_SYS_NUM,
  parameter int LVL_W = VIC_LVL_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ext_reset_n,
  input wire logic wdt_overflow,
  input wire logic wdt_reset_mode,
  input wire logic nmi_ack,
  input wire logic [7:0] port0_irq,
  input wire logic [7:0] port1_irq,
  input wire logic [2:0] stopwatch_irq,
  input wire logic [3:0] clock_timer_irq,
  input wire logic [5:0] pwm2_irq,
  input wire logic svd_irq,
  input wire logic lcd_irq,
  input wire logic [5:0] pwm0_irq,
  input wire logic [VIC_TIMER_NUM-1:0] timer_irq,
  input wire logic [5:0] pwm3_irq,
  input wire logic [VIC_MISC_NUM-1:0] misc_irq,
  input wire logic [SYS_NUM*LVL_W-1:0] sys_level,
  input wire logic psw_wr,
  input wire logic [VIC_PSW_W-1:0] psw_wdata,
  input wire logic sp_wr,
  input wire logic [VIC_ADDR_W-1:0] sp_wdata,
  input wire logic gpr_wr,
  input wire logic [2:0] gpr_waddr,
  input wire logic [VIC_ADDR_W-1:0] gpr_wdata,
  input wire logic [2:0] gpr_raddr,
  input wire logic vbase_low_wr,
  input wire logic vbase_high_wr,
  input wire logic [7:0] vbase_wdata,
  input wire logic key_wr,
  input wire logic [7:0] key_wdata,
  output logic irq_req,
  output logic [LVL_W-1:0] irq_level,
  output logic [VIC_VEC_W-1:0] irq_vector,
  output logic [VIC_ADDR_W-1:0] irq_vec_addr,
  output logic nmi_req,
  output logic reset_fetch,
  output logic [VIC_ADDR_W-1:0] reset_fetch_addr,
  output logic core_run,
  output logic [VIC_PSW_W-1:0] processor_status_word,
  output logic [VIC_ADDR_W-1:0] stack_pointer,
  output logic [VIC_ADDR_W-1:0] gpr_rdata,
  output logic [VIC_ADDR_W-1:0] vector_table_base,
  output logic [7:0] write_protect_key_reg
);

  vic_boot_t boot_state;
  vic_boot_t next_boot_state;
  logic reset_hold;
  logic init_clr;
  logic wdt_nmi_evt;
  logic [VIC_BASE_W-1:0] base;
  logic [SYS_NUM-1:0] sys_req;
  logic best_found;
  logic [LVL_W-1:0] best_lvl;
  logic [VIC_VEC_W-1:0] best_vec;
  logic [LVL_W-1:0] cur_level;
  logic cur_ie;
  logic next_irq_req;

  // reset sources: pin low or watchdog in reset mode
  assign reset_hold = !ext_reset_n || (wdt_overflow && wdt_reset_mode);
  assign wdt_nmi_evt = wdt_overflow && !wdt_reset_mode;
  // clear on the reset edge itself, so a core write in that cycle cannot survive it
  assign init_clr = (boot_state == VIC_BOOT_HOLD) || reset_hold;
  assign cur_level = processor_status_word[VIC_PSW_IL_LSB +: LVL_W];
  assign cur_ie = processor_status_word[VIC_PSW_IE_BIT];
  assign vector_table_base = {base, VIC_BASE_LOW_ZERO};
  assign reset_fetch = (boot_state == VIC_BOOT_FETCH);
  assign core_run = (boot_state == VIC_BOOT_RUN);

  // boot sequence: hold while any reset source is active, then one fetch of vector 0
  always_comb begin
    next_boot_state = boot_state;
    case (boot_state)
      VIC_BOOT_HOLD: begin
        if (!reset_hold) begin
          next_boot_state = VIC_BOOT_FETCH;
        end
      end
      VIC_BOOT_FETCH: begin
        next_boot_state = VIC_BOOT_RUN;
      end
      VIC_BOOT_RUN: begin
        next_boot_state = VIC_BOOT_RUN;
      end
      default: begin
        next_boot_state = VIC_BOOT_HOLD;
      end
    endcase
    if (reset_hold) begin
      next_boot_state = VIC_BOOT_HOLD;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      boot_state <= VIC_BOOT_HOLD;
    end else begin
      boot_state <= next_boot_state;
    end
  end

  // general registers cleared for the whole hold phase
  vic_gpr_mem #(
    .DEPTH(VIC_GPR_NUM),
    .WIDTH(VIC_ADDR_W)
  ) u_gpr (
    .mclk(mclk),
    .rst(rst),
    .clr(init_clr),
    .wr_en(gpr_wr && core_run),
    .wr_addr(gpr_waddr),
    .wr_data(gpr_wdata),
    .rd_addr(gpr_raddr),
    .rd_data(gpr_rdata)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      processor_status_word <= VIC_PSW_RESET;
    end else if (init_clr) begin
      processor_status_word <= VIC_PSW_RESET;
    end else if (psw_wr) begin
      processor_status_word <= psw_wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stack_pointer <= VIC_SP_RESET;
    end else if (init_clr) begin
      stack_pointer <= VIC_SP_RESET;
    end else if (sp_wr) begin
      stack_pointer <= sp_wdata;
    end
  end

  // reset entry address follows the base, which hold restores, so boot always fetches from 0x8000
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reset_fetch_addr <= {VIC_BASE_RESET, VIC_BASE_LOW_ZERO};
    end else begin
      reset_fetch_addr <= vic_vec_addr(base, VIC_VEC_RESET);
    end
  end

  // protect key and table base return to defaults on any initial reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      write_protect_key_reg <= VIC_KEY_RESET;
    end else if (init_clr) begin
      write_protect_key_reg <= VIC_KEY_RESET;
    end else if (key_wr) begin
      write_protect_key_reg <= key_wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      base <= VIC_BASE_RESET;
    end else if (init_clr) begin
      base <= VIC_BASE_RESET;
    end else if (write_protect_key_reg == VIC_KEY_OPEN) begin
      if (vbase_low_wr) begin
        base[7:0] <= vbase_wdata;
      end
      if (vbase_high_wr) begin
        base[15:8] <= vbase_wdata;
      end
    end
  end

  // nmi pending: a new overflow in the acknowledge cycle keeps it set
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nmi_req <= 1'b0;
    end else if (!core_run || reset_hold) begin
      nmi_req <= 1'b0;
    end else if (wdt_nmi_evt) begin
      nmi_req <= 1'b1;
    end else if (nmi_ack) begin
      nmi_req <= 1'b0;
    end
  end

  // one combined request per system; cause enables live in the peripherals
  always_comb begin
    sys_req = '0;
    sys_req[VIC_SYS_P0] = |port0_irq;
    sys_req[VIC_SYS_P1] = |port1_irq;
    sys_req[VIC_SYS_SW] = |stopwatch_irq;
    sys_req[VIC_SYS_CT] = |clock_timer_irq;
    sys_req[VIC_SYS_PWM2] = |pwm2_irq;
    sys_req[VIC_SYS_SVD] = svd_irq;
    sys_req[VIC_SYS_LCD] = lcd_irq;
    sys_req[VIC_SYS_PWM0] = |pwm0_irq;
    for (int t = 0; t < VIC_TIMER_NUM; t++) begin
      sys_req[VIC_SYS_T0 + t] = timer_irq[t];
    end
    // shared vector: one level for both, software reads both flags
    sys_req[VIC_SYS_T0 + VIC_TIMER_NUM - 1] = timer_irq[VIC_TIMER_NUM-1] | (|pwm3_irq);
    for (int m = 0; m < VIC_MISC_NUM; m++) begin
      sys_req[VIC_SYS_MISC + m] = misc_irq[m];
    end
  end

  // strict greater keeps the earlier, lower vector on a tie
  always_comb begin
    best_found = 1'b0;
    best_lvl = '0;
    best_vec = '0;
    for (int i = 0; i < SYS_NUM; i++) begin
      if (sys_req[i] && (!best_found || sys_level[i*LVL_W +: LVL_W] > best_lvl)) begin
        best_found = 1'b1;
        best_lvl = sys_level[i*LVL_W +: LVL_W];
        best_vec = vic_sys_vector(i);
      end
    end
  end

  // a reset source beats any maskable request in the same cycle
  assign next_irq_req = core_run && !reset_hold && best_found && cur_ie
    && (best_lvl > cur_level);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_req <= 1'b0;
      irq_level <= '0;
      irq_vector <= VIC_VEC_RESET;
      irq_vec_addr <= {VIC_BASE_RESET, VIC_BASE_LOW_ZERO};
    end else begin
      irq_req <= next_irq_req;
      irq_level <= best_lvl;
      irq_vector <= best_vec;
      irq_vec_addr <= vic_vec_addr(base, best_vec);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_psw_clear;
    !ext_reset_n |=> processor_status_word == VIC_PSW_RESET;
  endproperty
  a_psw_clear: assert property (p_psw_clear) else $error("status word not cleared");

  property p_boot_fetch;
    (boot_state == VIC_BOOT_HOLD) && !reset_hold ##1 !reset_hold && !sp_wr |-> reset_fetch
      ##1 core_run && !reset_fetch && stack_pointer == $past(stack_pointer, 2);
  endproperty
  a_boot_fetch: assert property (p_boot_fetch) else $error("boot fetch sequence wrong");

  property p_sp_zero;
    reset_fetch |-> stack_pointer == VIC_SP_RESET
      && reset_fetch_addr == vector_table_base;
  endproperty
  a_sp_zero: assert property (p_sp_zero) else $error("stack or fetch address wrong");

  property p_reset_wins;
    reset_hold |=> !core_run && !irq_req && !nmi_req;
  endproperty
  a_reset_wins: assert property (p_reset_wins) else $error("reset did not hold core");

  property p_vec_addr;
    irq_req |-> irq_vector != VIC_VEC_RSVD && irq_vector >= VIC_VEC_FIRST
      && irq_vec_addr == vic_vec_addr($past(base), irq_vector);
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

  property p_nmi_set;
    core_run && wdt_nmi_evt && !reset_hold |=> nmi_req;
  endproperty
  a_nmi_set: assert property (p_nmi_set) else $error("nmi not raised");

  property p_base_lock;
    (vbase_low_wr || vbase_high_wr) && write_protect_key_reg != VIC_KEY_OPEN && core_run
      && !reset_hold |=> $stable(base);
  endproperty
  a_base_lock: assert property (p_base_lock) else $error("locked base changed");

  property p_level_gate;
    irq_req |-> $past(cur_ie) && irq_level > $past(cur_level);
  endproperty
  a_level_gate: assert property (p_level_gate) else $error("request at too low level");

  property p_port0_first;
    core_run && cur_ie && (|port0_irq) && sys_level[VIC_SYS_P0*LVL_W +: LVL_W] == '1
      && cur_level != '1 && !reset_hold |=> irq_req && irq_vector == VIC_VEC_FIRST;
  endproperty
  a_port0_first: assert property (p_port0_first) else $error("port group 0 not first");

  property p_init_clear;
    reset_hold |=> processor_status_word == VIC_PSW_RESET && stack_pointer == VIC_SP_RESET
      && write_protect_key_reg == VIC_KEY_RESET && base == VIC_BASE_RESET;
  endproperty
  a_init_clear: assert property (p_init_clear) else $error("registers not cleared by reset");

  property p_irq_off;
    !cur_ie || !core_run |=> !irq_req;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request while masked");

  property p_nmi_hold;
    nmi_req && !nmi_ack && core_run && !reset_hold |=> nmi_req;
  endproperty
  a_nmi_hold: assert property (p_nmi_hold) else $error("nmi dropped before ack");

  c_irq: cover property (irq_req ##1 !irq_req);
  c_nmi: cover property (nmi_req && nmi_ack);
  c_boot: cover property (reset_fetch ##1 core_run);
  c_shared: cover property (irq_req && irq_vector == vic_sys_vector(VIC_SYS_T0 + VIC_TIMER_NUM - 1));

endmodule
`default_nettype wire

// ---- src/vic_pkg.sv ----
package vic_pkg;

  localparam int VIC_SYS_NUM = 22;
  localparam int VIC_LVL_W = 3;
  localparam int VIC_VEC_W = 5;
  localparam int VIC_ADDR_W = 24;
  localparam int VIC_BASE_W = 16;
  localparam int VIC_GPR_NUM = 8;
  localparam int VIC_MISC_NUM = 10;
  localparam int VIC_PSW_W = 8;
  localparam int VIC_PSW_IL_LSB = 5;
  localparam int VIC_PSW_IE_BIT = 4;
  localparam int VIC_VEC_SHIFT = 2;
  localparam int VIC_GAP_SYS = 13;

  // system index of each request group, in vector order
  localparam int VIC_SYS_P0 = 0;
  localparam int VIC_SYS_P1 = 1;
  localparam int VIC_SYS_SW = 2;
  localparam int VIC_SYS_CT = 3;
  localparam int VIC_SYS_PWM2 = 4;
  localparam int VIC_SYS_SVD = 5;
  localparam int VIC_SYS_LCD = 6;
  localparam int VIC_SYS_PWM0 = 7;
  localparam int VIC_SYS_T0 = 8;
  localparam int VIC_TIMER_NUM = 4;
  localparam int VIC_SYS_MISC = 12;

  localparam logic [VIC_VEC_W-1:0] VIC_VEC_RESET = 5'h00;
  localparam logic [VIC_VEC_W-1:0] VIC_VEC_NMI = 5'h02;
  localparam logic [VIC_VEC_W-1:0] VIC_VEC_RSVD = 5'h03;
  localparam logic [VIC_VEC_W-1:0] VIC_VEC_FIRST = 5'h04;
  localparam logic [VIC_BASE_W-1:0] VIC_BASE_RESET = 16'h0080;
  localparam logic [7:0] VIC_BASE_LOW_ZERO = 8'h00;
  localparam logic [7:0] VIC_KEY_OPEN = 8'h96;
  localparam logic [7:0] VIC_KEY_RESET = 8'h00;
  localparam logic [VIC_PSW_W-1:0] VIC_PSW_RESET = 8'h00;
  localparam logic [VIC_ADDR_W-1:0] VIC_SP_RESET = 24'h000000;
  localparam logic [VIC_ADDR_W-1:0] VIC_GPR_RESET = 24'h000000;

  typedef enum logic [1:0] {
    VIC_BOOT_HOLD,
    VIC_BOOT_FETCH,
    VIC_BOOT_RUN
  } vic_boot_t;

  function automatic logic [VIC_VEC_W-1:0] vic_sys_vector(input int idx);
    // vector 17 is skipped between the uart group and the rest
    if (idx < VIC_GAP_SYS) begin
      return VIC_VEC_FIRST + VIC_VEC_W'(idx);
    end
    return VIC_VEC_FIRST + VIC_VEC_W'(idx + 1);
  endfunction

  function automatic logic [VIC_ADDR_W-1:0] vic_vec_addr(input logic [VIC_BASE_W-1:0] base,
                                                         input logic [VIC_VEC_W-1:0] vec);
    return {base, VIC_BASE_LOW_ZERO} + (VIC_ADDR_W'(vec) << VIC_VEC_SHIFT);
  endfunction

endpackage

// ---- tb/vic_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module vic_core_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic nmi_req,
  input wire logic [3:0] ack_wait,
  output logic nmi_ack
);
  // a slow core lets the request stand for several cycles before taking it
  logic [3:0] wait_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nmi_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (nmi_ack) begin
      nmi_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (nmi_req === 1'b1) begin
      if (wait_cnt >= ack_wait) begin
        nmi_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
  // no ram or display memory is modelled; the core's software owns their setup
endmodule
`default_nettype wire

// ---- tb/vic_interrupt_arbiter_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module vic_interrupt_arbiter_test import vic_pkg::*; ;
  logic mclk, rst, ext_reset_n, wdt_overflow, wdt_reset_mode, nmi_ack, svd_irq, lcd_irq;
  logic [7:0] port0_irq, port1_irq, psw_wdata, vbase_wdata, key_wdata;
  logic [2:0] stopwatch_irq, gpr_waddr, gpr_raddr, irq_level;
  logic [3:0] clock_timer_irq, timer_irq, ack_wait;
  logic [5:0] pwm2_irq, pwm0_irq, pwm3_irq;
  logic [9:0] misc_irq;
  logic [65:0] sys_level;
  logic psw_wr, sp_wr, gpr_wr, vbase_low_wr, vbase_high_wr, key_wr;
  logic [23:0] sp_wdata, gpr_wdata, irq_vec_addr, reset_fetch_addr, stack_pointer;
  logic [23:0] gpr_rdata, vector_table_base, base_exp;
  logic irq_req, nmi_req, reset_fetch, core_run;
  logic [4:0] irq_vector;
  logic [7:0] processor_status_word, write_protect_key_reg;
  logic [31:0] seed = 32'h445c206d;
  typedef struct {int sel; logic [23:0] exp;} vic_note_t;
  vic_note_t notes[$];
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  event obs_ev;

  vic_interrupt_arbiter dut_u (.mclk, .rst, .ext_reset_n, .wdt_overflow, .wdt_reset_mode,
    .nmi_ack, .port0_irq, .port1_irq, .stopwatch_irq, .clock_timer_irq, .pwm2_irq, .svd_irq,
    .lcd_irq, .pwm0_irq, .timer_irq, .pwm3_irq, .misc_irq, .sys_level, .psw_wr, .psw_wdata,
    .sp_wr, .sp_wdata, .gpr_wr, .gpr_waddr, .gpr_wdata, .gpr_raddr, .vbase_low_wr,
    .vbase_high_wr, .vbase_wdata, .key_wr, .key_wdata, .irq_req, .irq_level, .irq_vector,
    .irq_vec_addr, .nmi_req, .reset_fetch, .reset_fetch_addr, .core_run,
    .processor_status_word, .stack_pointer, .gpr_rdata, .vector_table_base,
    .write_protect_key_reg);
  vic_core_model core_u (.mclk, .rst, .nmi_req, .ack_wait, .nmi_ack);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    logic [31:0] x;
    x = seed;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    seed = x;
    return x;
  endfunction

  function automatic logic [23:0] obs(input int sel);
    case (sel)
      0: return 24'(irq_req);
      1: return 24'(irq_level);
      2: return 24'(irq_vector);
      3: return irq_vec_addr;
      4: return 24'(nmi_req);
      5: return 24'(reset_fetch);
      6: return 24'(core_run);
      7: return 24'(processor_status_word);
      8: return stack_pointer;
      9: return gpr_rdata;
      10: return vector_table_base;
      11: return 24'(write_protect_key_reg);
      default: return reset_fetch_addr;
    endcase
  endfunction

  // systems past the uart slot sit one vector higher
  function automatic int vec_of(input int i);
    return (i < 13) ? i + 4 : i + 5;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic note(input int sel, input logic [23:0] exp);
    notes.push_back('{sel, exp});
    ->obs_ev;
  endtask

  initial begin
    vic_note_t n;
    forever begin
      @(obs_ev);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        check_val(obs(n.sel), n.exp);
      end
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles > 5000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic quiet();
    {port0_irq, port1_irq, stopwatch_irq, clock_timer_irq, pwm2_irq, svd_irq} = 30'h0;
    {lcd_irq, pwm0_irq, timer_irq, pwm3_irq, misc_irq, wdt_overflow} = 28'h0;
  endtask

  // kinds: 0 status, 1 stack, 2 key, 3 base low, 4 base high, 5+n general register n
  task automatic wr(input int kind, input logic [23:0] v);
    case (kind)
      0: psw_wr = 1'b1;
      1: sp_wr = 1'b1;
      2: key_wr = 1'b1;
      3: vbase_low_wr = 1'b1;
      4: vbase_high_wr = 1'b1;
      default: gpr_wr = 1'b1;
    endcase
    {psw_wdata, key_wdata, vbase_wdata} = {3{v[7:0]}};
    {sp_wdata, gpr_wdata} = {v, v};
    gpr_waddr = 3'(kind - 5);
    cyc(1);
    {psw_wr, sp_wr, key_wr, vbase_low_wr, vbase_high_wr, gpr_wr} = 6'h00;
    cyc(1);
  endtask

  task automatic raise(input int i, input logic [31:0] r);
    case (i)
      0: port0_irq[r % 8] = 1'b1;
      1: port1_irq[r % 8] = 1'b1;
      2: stopwatch_irq[r % 3] = 1'b1;
      3: clock_timer_irq[r % 4] = 1'b1;
      4: pwm2_irq[r % 6] = 1'b1;
      5: svd_irq = 1'b1;
      6: lcd_irq = 1'b1;
      7: pwm0_irq[r % 6] = 1'b1;
      8, 9, 10: timer_irq[i - 8] = 1'b1;
      11: if (r[0]) pwm3_irq[r % 6] = 1'b1; else timer_irq[3] = 1'b1;
      default: misc_irq[i - 12] = 1'b1;
    endcase
  endtask

  task automatic exp_irq(input int i, input int lvl);
    note(0, 24'h1);
    note(1, 24'(lvl));
    note(2, 24'(vec_of(i)));
    note(3, base_exp + 24'(4 * vec_of(i)));
  endtask

  initial begin
    int a, b, x, y, la, lb;
    logic [31:0] r;
    {rst, ext_reset_n} = 2'h3;
    {wdt_reset_mode, ack_wait, sys_level, gpr_raddr} = 74'h0;
    {psw_wr, sp_wr, key_wr, vbase_low_wr, vbase_high_wr, gpr_wr} = 6'h00;
    {psw_wdata, key_wdata, vbase_wdata, sp_wdata, gpr_wdata, gpr_waddr} = 75'h0;
    base_exp = 24'h008000;
    quiet();
    cyc(1);
    note(7, 24'h0);
    note(8, 24'h0);
    note(9, 24'h0);
    note(10, 24'h008000);
    note(11, 24'h0);
    note(12, 24'h008000);
    note(6, 24'h0);
    cyc(1);
    rst = 1'b0;
    cyc(1);
    note(5, 24'h1);
    cyc(1);
    note(6, 24'h1);
    for (a = 0; a < 8; a++) begin
      gpr_raddr = 3'(a);
      cyc(1);
      note(9, 24'h0);
    end
    $display("test reset done");
    wr(0, 24'h10);
    note(7, 24'h10);
    for (a = 0; a < 22; a++) begin
      quiet();
      sys_level = 66'({rnd(), rnd(), rnd()});
      la = a % 7 + 1;
      sys_level[3*a +: 3] = 3'(la);
      raise(a, rnd());
      cyc(1);
      exp_irq(a, la);
    end
    quiet();
    pwm3_irq = 6'h20;
    cyc(1);
    note(2, 24'h0f);
    quiet();
    sys_level = '1;
    port0_irq = 8'h80;
    misc_irq[9] = 1'b1;
    cyc(1);
    note(1, 24'h7);
    note(2, 24'h04);
    $display("test systems done");
    for (a = 0; a < 12; a++) begin
      quiet();
      r = rnd();
      x = int'(r % 22);
      y = (x + 1 + int'(r[15:8]) % 21) % 22;
      la = int'(r[18:16]) % 7 + 1;
      lb = (a % 2 == 1) ? la : int'(r[21:19]) % 7 + 1;
      sys_level[3*x +: 3] = 3'(la);
      sys_level[3*y +: 3] = 3'(lb);
      raise(x, rnd());
      raise(y, rnd());
      cyc(1);
      note(1, 24'((la > lb) ? la : lb));
      note(2, 24'(vec_of((la > lb || (la == lb && x < y)) ? x : y)));
    end
    $display("test priority done");
    quiet();
    sys_level = 66'h0;
    sys_level[2:0] = 3'h5;
    port0_irq = 8'h01;
    wr(0, 24'hb0);
    note(0, 24'h0);
    wr(0, 24'h90);
    note(0, 24'h1);
    note(1, 24'h5);
    wr(0, 24'he0);
    note(0, 24'h0);
    sys_level[2:0] = 3'h0;
    wr(0, 24'h10);
    note(0, 24'h0);
    $display("test refusal done");
    for (a = 0; a < 2; a++) begin
      ack_wait = 4'(a * 3);
      wdt_overflow = 1'b1;
      cyc(1);
      wdt_overflow = 1'b0;
      note(4, 24'h1);
      for (b = 0; b < 12 && nmi_req === 1'b1; b++) cyc(1);
      note(4, 24'h0);
    end
    {wdt_reset_mode, wdt_overflow} = 2'h3;
    cyc(1);
    {wdt_reset_mode, wdt_overflow} = 2'h0;
    note(6, 24'h0);
    note(7, 24'h0);
    note(4, 24'h0);
    for (b = 0; b < 8 && core_run !== 1'b1; b++) cyc(1);
    note(6, 24'h1);
    $display("test watchdog done");
    r = rnd();
    wr(8, r[23:0]);
    wr(1, r[31:8]);
    note(8, r[31:8]);
    wr(2, 24'h96);
    note(11, 24'h96);
    wr(4, 24'h05);
    note(10, 24'h058000);
    gpr_raddr = 3'h3;
    cyc(1);
    note(9, r[23:0]);
    ext_reset_n = 1'b0;
    cyc(1);
    note(8, 24'h0);
    note(11, 24'h0);
    note(10, 24'h008000);
    note(6, 24'h0);
    cyc(1);
    note(9, 24'h0);
    ext_reset_n = 1'b1;
    cyc(1);
    note(5, 24'h1);
    note(12, 24'h008000);
    cyc(1);
    note(6, 24'h1);
    $display("test pin reset done");
    wr(4, 24'h07);
    note(10, 24'h008000);
    wr(2, 24'h96);
    wr(4, 24'h01);
    wr(3, 24'h12);
    wr(2, 24'h00);
    base_exp = 24'h011200;
    note(10, base_exp);
    wr(3, 24'h34);
    note(10, base_exp);
    wr(0, 24'h10);
    quiet();
    sys_level = 66'h0;
    sys_level[62:60] = 3'h3;
    misc_irq[8] = 1'b1;
    cyc(1);
    exp_irq(20, 3);
    $display("test base done");
    cyc(1);
    stop_test();
  end
endmodule
`default_nettype wire
